// File: rtl/move_decode_pkg.sv
// Purpose: shared constants and types for the data move decoder
// Assumes: one core clock, byte-wide instruction stream
// Notes: opcodes and sub-codes are the instruction encodings

package move_decode_pkg;

   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_ESCAPE = 8'hA5;
   localparam logic [7:0] OP_STORE_DIR16 = 8'h7A;
   localparam logic [7:0] OP_STORE_WORD_PTR = 8'h1B;
   localparam logic [7:0] OP_LD_B_WDISP = 8'h09;
   localparam logic [7:0] OP_LD_W_WDISP = 8'h49;
   localparam logic [7:0] OP_LD_B_DDISP = 8'h29;
   localparam logic [7:0] OP_LD_W_DDISP = 8'h69;
   localparam logic [7:0] OP_ST_B_WDISP = 8'h19;
   localparam logic [7:0] OP_ST_W_WDISP = 8'h59;
   localparam logic [7:0] OP_ST_B_DDISP = 8'h39;
   localparam logic [7:0] OP_ST_W_DDISP = 8'h79;
   localparam logic [7:0] OP_BIT_STORE = 8'h92;
   localparam logic [7:0] OP_BIT_LOAD = 8'hA2;
   localparam logic [7:0] OP_BIT_EXT = 8'hA9;
   localparam logic [7:0] OP_LOAD_POINTER = 8'h90;
   localparam logic [7:0] OP_CODE_PC = 8'h83;
   localparam logic [7:0] OP_CODE_POINTER = 8'h93;
   localparam logic [7:0] OP_SIGN_EXTEND = 8'h1A;

   // ------------------------------------------------------------
   // sub-codes in the low nibble of the first operand byte; bit move sub-codes in the high nibble
   // ------------------------------------------------------------
   localparam logic [3:0] SUB_BYTE = 4'h3;
   localparam logic [3:0] SUB_DWORD = 4'hF;
   localparam logic [3:0] SUB_BYTE_WPTR = 4'h9;
   localparam logic [3:0] SUB_BYTE_DATA_POINTER = 4'hB;
   localparam logic [3:0] SUB_WORD_WPTR = 4'h8;
   localparam logic [3:0] SUB_WORD_DATA_POINTER = 4'hA;
   localparam logic [3:0] SUB_HIGH_WORD = 4'hC;
   localparam logic [3:0] BITSUB_STORE = 4'h9;
   localparam logic [3:0] BITSUB_LOAD = 4'hA;

   // ------------------------------------------------------------
   // memory request encodings and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] SPACE_DATA = 2'h0;
   localparam logic [1:0] SPACE_CODE = 2'h1;
   localparam logic [1:0] SPACE_BIT = 2'h2;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_DWORD = 2'h3;
   localparam int REG_FILE_BYTES = 64;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [15:0] POINTER_RESET = 16'h0000;
   localparam logic CARRY_RESET = 1'b0;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] space;
      logic [1:0] size;
      logic [23:0] addr;
      logic [31:0] wdata;
   } memReq_t;

   typedef enum logic [2:0] {
      S_OP = 3'b000,
      S_ARG = 3'b001,
      S_EXEC = 3'b011,
      S_WAIT = 3'b010
   } state_t;

endpackage

// File: rtl/move_address_gen.sv
// Purpose: operand address adder for pointer, displacement and table reads
// Assumes: offset is a signed displacement in wide mode
// Notes: narrow mode wraps inside 64 KB, wide mode inside 16 MB

`timescale 1ns/1ns

module move_address_gen
   import move_decode_pkg::*;
(
   input wire logic [23:0] base,
   input wire logic [15:0] offset,
   input wire logic wide,
   output logic [23:0] addr
);

   logic [15:0] narrowSum;
   logic [23:0] wideSum;

   // narrow sum drops the carry out of bit 15 on purpose
   assign narrowSum = base[15:0] + offset;
   assign wideSum = base + {{8{offset[15]}}, offset};
   assign addr = wide ? wideSum : {8'h00, narrowSum};

endmodule

// File: rtl/data_move_instruction_decode.sv
// Purpose: decode and execute a group of data transfer instructions
// Assumes: instruction bytes arrive in order with the address of each byte
// Notes: one memory request at a time, held until acknowledged
// Summary of operation
// - binary mode needs escape prefix before extended moves; source mode decodes directly
// - opcode 7A stores register to 16-bit direct address, sub-code 3 byte, F dword
// - sub-codes 9 and B store byte register through word or dword pointer
// - opcodes 09 and 49 load from word pointer plus signed displacement
// - dword pointer displacement moves add the displacement over 24 bits
// - opcodes 19, 59, 39, 79 store register to pointer plus displacement
// - bit moves copy one bit between carry and an addressable bit
// - a bit move changes only its destination bit
// - opcode 90 loads data pointer high and low bytes from immediate
// - code byte read address is 16-bit sum of accumulator and base
// - program counter base is advanced to next instruction before the add
// - 83 reads with program counter base, 93 with data pointer, left unchanged
// - high word load writes upper half of dword register, keeps lower half
// - sign extend move fills upper byte with source most significant bit

`timescale 1ns/1ns

module data_move_instruction_decode
   import move_decode_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sourceMode,
   input wire logic fetchValid,
   input wire logic [7:0] fetchByte,
   input wire logic [15:0] fetchPc,
   output logic fetchReady,
   output memReq_t memReq,
   input wire logic memAck,
   input wire logic [31:0] memRdata,
   output logic [7:0] acc,
   output logic [15:0] dataPointer,
   output logic carryBit,
   output logic instrDone,
   output logic instrIllegal
);

   state_t state, next_state;
   logic prefix, next_prefix;
   logic [7:0] op, next_op, a0, next_a0, a1, next_a1, a2, next_a2;
   logic [1:0] argCnt, next_argCnt;
   logic [15:0] opPc, next_opPc;
   logic [7:0] regFile [REG_FILE_BYTES], next_regFile [REG_FILE_BYTES];
   logic [7:0] next_acc;
   logic [15:0] next_dataPointer;
   logic next_carryBit, next_instrDone, next_instrIllegal;
   memReq_t next_memReq;
   logic [23:0] agBase, agAddr;
   logic [15:0] agOffset;
   logic agWide, accept;
   logic [31:0] upperDword, lowerDword;
   logic [7:0] lowerByte;

   // ------------------------------------------------------------
   // register file views
   // ------------------------------------------------------------
   // nibble to register
   function automatic logic [7:0] byteOf(input logic [3:0] n);
      return regFile[{2'b00, n}];
   endfunction

   function automatic logic [15:0] wordOf(input logic [3:0] n);
      return {regFile[{1'b0, n, 1'b0}], regFile[{1'b0, n, 1'b1}]};
   endfunction

   function automatic logic [31:0] dwordOf(input logic [3:0] n);
      return {regFile[{n, 2'b00}], regFile[{n, 2'b01}], regFile[{n, 2'b10}],
              regFile[{n, 2'b11}]};
   endfunction

   // ------------------------------------------------------------
   // opcode classes
   // ------------------------------------------------------------
   function automatic logic isCompat(input logic [7:0] o);
      return o == OP_LOAD_POINTER || o == OP_BIT_STORE || o == OP_BIT_LOAD ||
             o == OP_CODE_PC || o == OP_CODE_POINTER;
   endfunction

   function automatic logic isExtended(input logic [7:0] o);
      return o == OP_STORE_DIR16 || o == OP_STORE_WORD_PTR || o == OP_LD_B_WDISP ||
             o == OP_LD_W_WDISP || o == OP_LD_B_DDISP || o == OP_LD_W_DDISP ||
             o == OP_ST_B_WDISP || o == OP_ST_W_WDISP || o == OP_ST_B_DDISP ||
             o == OP_ST_W_DDISP || o == OP_BIT_EXT || o == OP_SIGN_EXTEND;
   endfunction

   // operand bytes after the opcode; 7A depends on its sub-code
   function automatic logic [1:0] argsNeeded(input logic [7:0] o, input logic [3:0] sub);
      case (o)
         OP_STORE_DIR16: return (sub == SUB_BYTE_WPTR || sub == SUB_BYTE_DATA_POINTER) ? 2'd2 : 2'd3;
         OP_STORE_WORD_PTR, OP_BIT_EXT, OP_LOAD_POINTER: return 2'd2;
         OP_BIT_STORE, OP_BIT_LOAD, OP_SIGN_EXTEND: return 2'd1;
         default: return 2'd3;
      endcase
   endfunction

   // operand views named once, since a function result takes no part-select
   always_comb
   begin
      upperDword = dwordOf(a0[7:4]);
      lowerDword = dwordOf(a0[3:0]);
      lowerByte = byteOf(a0[3:0]);
   end

   assign fetchReady = (state == S_OP) || (state == S_ARG);
   assign accept = fetchValid && fetchReady;

   // ------------------------------------------------------------
   // operand address selection
   // ------------------------------------------------------------
   // one shared adder; the opcode, and for 7A and 1B the sub-code, picks base, offset and width
   always_comb
   begin
      agBase = 24'h000000;
      agOffset = 16'h0000;
      agWide = 1'b0;
      case (op)
         OP_STORE_DIR16, OP_STORE_WORD_PTR:
         begin
            if (a0[3:0] == SUB_BYTE || a0[3:0] == SUB_DWORD)
               agBase = {8'h00, a1, a2};
            else if (a0[3:0] == SUB_BYTE_WPTR || a0[3:0] == SUB_WORD_WPTR)
               agBase = {8'h00, wordOf(a0[7:4])};
            else
            begin
               // dword pointers keep their upper address byte
               agBase = upperDword[23:0];
               agWide = 1'b1;
            end
         end
         OP_LD_B_WDISP, OP_LD_W_WDISP, OP_ST_B_WDISP, OP_ST_W_WDISP:
         begin
            agBase = {8'h00, wordOf(a0[3:0])};
            agOffset = {a1, a2};
         end
         OP_LD_B_DDISP, OP_LD_W_DDISP, OP_ST_B_DDISP, OP_ST_W_DDISP:
         begin
            agBase = lowerDword[23:0];
            agOffset = {a1, a2};
            agWide = 1'b1;
         end
         OP_CODE_PC:
         begin
            agBase = {8'h00, opPc + 16'h0001};
            agOffset = {8'h00, acc};
         end
         OP_CODE_POINTER:
         begin
            agBase = {8'h00, dataPointer};
            agOffset = {8'h00, acc};
         end
         default:
         begin
            agBase = 24'h000000;
         end
      endcase
   end

   move_address_gen u_addr (
      .base(agBase),
      .offset(agOffset),
      .wide(agWide),
      .addr(agAddr)
   );

   // ------------------------------------------------------------
   // decode and execute sequencer
   // ------------------------------------------------------------
   // next values for every piece of architectural and sequencing state
   always_comb
   begin
      logic issue;
      logic [3:0] sub;
      issue = 1'b0;
      sub = 4'h0;
      next_state = state;
      next_prefix = prefix;
      next_op = op;
      next_a0 = a0;
      next_a1 = a1;
      next_a2 = a2;
      next_argCnt = argCnt;
      next_opPc = opPc;
      next_regFile = regFile;
      next_acc = acc;
      next_dataPointer = dataPointer;
      next_carryBit = carryBit;
      next_memReq = memReq;
      next_instrDone = 1'b0;
      next_instrIllegal = 1'b0;
      case (state)
         S_OP:
         begin
            if (accept && fetchByte == OP_ESCAPE && !prefix)
               next_prefix = 1'b1;
            else if (accept)
            begin
               next_op = fetchByte;
               next_opPc = fetchPc;
               next_argCnt = 2'd0;
               next_prefix = 1'b0;
               // prefix needed only in binary mode
               if (isCompat(fetchByte) || (isExtended(fetchByte) && (prefix ^ sourceMode)))
                  next_state = (fetchByte == OP_CODE_PC || fetchByte == OP_CODE_POINTER) ?
                               S_EXEC : S_ARG;
               else
                  next_instrIllegal = 1'b1;
            end
         end
         S_ARG:
         begin
            if (accept)
            begin
               sub = (argCnt == 2'd0) ? fetchByte[3:0] : a0[3:0];
               if (argCnt == 2'd0)
                  next_a0 = fetchByte;
               else if (argCnt == 2'd1)
                  next_a1 = fetchByte;
               else
                  next_a2 = fetchByte;
               next_argCnt = argCnt + 2'd1;
               if (argCnt + 2'd1 == argsNeeded(op, sub))
                  next_state = S_EXEC;
            end
         end
         S_EXEC:
         begin
            next_state = S_OP;
            next_memReq.addr = agAddr;
            next_memReq.space = SPACE_DATA;
            next_memReq.write = 1'b1;
            next_memReq.size = SIZE_BYTE;
            next_memReq.wdata = 32'h00000000;
            case (op)
               OP_STORE_DIR16:
               begin
                  if (a0[3:0] == SUB_BYTE)
                  begin
                     issue = 1'b1;
                     next_memReq.wdata = {24'h000000, byteOf(a0[7:4])};
                  end
                  else if (a0[3:0] == SUB_DWORD)
                  begin
                     issue = 1'b1;
                     next_memReq.size = SIZE_DWORD;
                     next_memReq.wdata = dwordOf(a0[7:4]);
                  end
                  else if (a0[3:0] == SUB_BYTE_WPTR || a0[3:0] == SUB_BYTE_DATA_POINTER)
                  begin
                     issue = 1'b1;
                     next_memReq.wdata = {24'h000000, byteOf(a1[7:4])};
                  end
                  else if (a0[3:0] == SUB_HIGH_WORD)
                  begin
                     next_regFile[{a0[7:4], 2'b00}] = a1;
                     next_regFile[{a0[7:4], 2'b01}] = a2;
                     next_instrDone = 1'b1;
                  end
                  else
                     next_instrIllegal = 1'b1;
               end
               OP_STORE_WORD_PTR:
               begin
                  issue = (a0[3:0] == SUB_WORD_WPTR) || (a0[3:0] == SUB_WORD_DATA_POINTER);
                  next_instrIllegal = !issue;
                  next_memReq.size = SIZE_WORD;
                  next_memReq.wdata = {16'h0000, wordOf(a1[7:4])};
               end
               OP_LD_B_WDISP, OP_LD_B_DDISP, OP_LD_W_WDISP, OP_LD_W_DDISP:
               begin
                  issue = 1'b1;
                  next_memReq.write = 1'b0;
                  next_memReq.size = op[6] ? SIZE_WORD : SIZE_BYTE;
               end
               OP_ST_B_WDISP, OP_ST_B_DDISP, OP_ST_W_WDISP, OP_ST_W_DDISP:
               begin
                  issue = 1'b1;
                  next_memReq.size = op[6] ? SIZE_WORD : SIZE_BYTE;
                  next_memReq.wdata = op[6] ? {16'h0000, wordOf(a0[7:4])} :
                                      {24'h000000, byteOf(a0[7:4])};
               end
               OP_BIT_STORE, OP_BIT_LOAD:
               begin
                  issue = 1'b1;
                  next_memReq.space = SPACE_BIT;
                  next_memReq.write = (op == OP_BIT_STORE);
                  next_memReq.addr = {16'h0000, a0};
                  next_memReq.wdata = {31'h00000000, carryBit};
               end
               OP_BIT_EXT:
               begin
                  issue = !a0[3] && (a0[7:4] == BITSUB_STORE || a0[7:4] == BITSUB_LOAD);
                  next_instrIllegal = !issue;
                  next_memReq.space = SPACE_BIT;
                  next_memReq.write = (a0[7:4] == BITSUB_STORE);
                  next_memReq.addr = {12'h001, 1'b0, a1, a0[2:0]};
                  next_memReq.wdata = {31'h00000000, carryBit};
               end
               OP_LOAD_POINTER:
               begin
                  next_dataPointer = {a0, a1};
                  next_instrDone = 1'b1;
               end
               OP_CODE_PC, OP_CODE_POINTER:
               begin
                  issue = 1'b1;
                  next_memReq.write = 1'b0;
                  next_memReq.space = SPACE_CODE;
               end
               OP_SIGN_EXTEND:
               begin
                  next_regFile[{1'b0, a0[7:4], 1'b0}] = {8{lowerByte[7]}};
                  next_regFile[{1'b0, a0[7:4], 1'b1}] = lowerByte;
                  next_instrDone = 1'b1;
               end
               default:
               begin
                  next_instrIllegal = 1'b1;
               end
            endcase
            if (issue)
            begin
               next_memReq.valid = 1'b1;
               next_state = S_WAIT;
            end
         end
         S_WAIT:
         begin
            if (memAck)
            begin
               next_memReq.valid = 1'b0;
               next_instrDone = 1'b1;
               next_state = S_OP;
               if (!memReq.write)
               begin
                  if (memReq.space == SPACE_BIT)
                     next_carryBit = memRdata[0];
                  else if (memReq.space == SPACE_CODE)
                     next_acc = memRdata[7:0];
                  else if (op[6])
                  begin
                     next_regFile[{1'b0, a0[7:4], 1'b0}] = memRdata[15:8];
                     next_regFile[{1'b0, a0[7:4], 1'b1}] = memRdata[7:0];
                  end
                  else
                     next_regFile[{2'b00, a0[7:4]}] = memRdata[7:0];
               end
            end
         end
         default:
         begin
            next_state = S_OP;
         end
      endcase
   end

   // state registers only
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= S_OP;
         prefix <= 1'b0;
         op <= 8'h00;
         a0 <= 8'h00;
         a1 <= 8'h00;
         a2 <= 8'h00;
         argCnt <= 2'd0;
         opPc <= 16'h0000;
         for (int i = 0; i < REG_FILE_BYTES; i++)
            regFile[i] <= REG_RESET;
         acc <= ACC_RESET;
         dataPointer <= POINTER_RESET;
         carryBit <= CARRY_RESET;
         memReq <= '0;
         instrDone <= 1'b0;
         instrIllegal <= 1'b0;
      end
      else
      begin
         state <= next_state;
         prefix <= next_prefix;
         op <= next_op;
         a0 <= next_a0;
         a1 <= next_a1;
         a2 <= next_a2;
         argCnt <= next_argCnt;
         opPc <= next_opPc;
         regFile <= next_regFile;
         acc <= next_acc;
         dataPointer <= next_dataPointer;
         carryBit <= next_carryBit;
         memReq <= next_memReq;
         instrDone <= next_instrDone;
         instrIllegal <= next_instrIllegal;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_escape;
      state == S_OP && accept && !sourceMode && !prefix && fetchByte == OP_STORE_DIR16
      |=> instrIllegal && state == S_OP;
   endproperty
   a_escape: assert property (p_escape) else $error("unprefixed extended op accepted");

   property p_dir16;
      state == S_EXEC && op == OP_STORE_DIR16 && a0[3:0] == SUB_BYTE
      |=> memReq.valid && memReq.write && memReq.size == SIZE_BYTE &&
          memReq.addr == {8'h00, a1, a2};
   endproperty
   a_dir16: assert property (p_dir16) else $error("direct store request wrong");

   property p_wide_disp;
      state == S_EXEC && op == OP_LD_B_DDISP
      |=> memReq.addr == $past(lowerDword[23:0] + {{8{a1[7]}}, a1, a2});
   endproperty
   a_wide_disp: assert property (p_wide_disp) else $error("24-bit displacement sum wrong");

   property p_bit_load;
      state == S_WAIT && memAck && memReq.space == SPACE_BIT && !memReq.write
      |=> carryBit == $past(memRdata[0]) && $stable(acc) && $stable(dataPointer);
   endproperty
   a_bit_load: assert property (p_bit_load) else $error("bit load wrong");

   property p_pointer_load;
      state == S_EXEC && op == OP_LOAD_POINTER
      |=> dataPointer[15:8] == $past(a0) && dataPointer[7:0] == $past(a1) && instrDone;
   endproperty
   a_pointer_load: assert property (p_pointer_load) else $error("pointer load wrong");

   property p_table_pointer;
      state == S_EXEC && op == OP_CODE_POINTER
      |=> memReq.space == SPACE_CODE && memReq.addr == {8'h00, $past(dataPointer + {8'h00, acc})}
          ##1 $stable(dataPointer) [*2];
   endproperty
   a_table_pointer: assert property (p_table_pointer) else $error("table read wrong");

   property p_table_pc;
      state == S_EXEC && op == OP_CODE_PC
      |=> memReq.addr[15:0] == $past(opPc + 16'h0001 + {8'h00, acc});
   endproperty
   a_table_pc: assert property (p_table_pc) else $error("pc table address wrong");

   property p_high_word;
      state == S_EXEC && op == OP_STORE_DIR16 && a0[3:0] == SUB_HIGH_WORD
      |=> regFile[{a0[7:4], 2'b10}] == $past(regFile[{a0[7:4], 2'b10}]) &&
          regFile[{a0[7:4], 2'b00}] == a1;
   endproperty
   a_high_word: assert property (p_high_word) else $error("high word load wrong");

   property p_sign;
      state == S_EXEC && op == OP_SIGN_EXTEND
      |=> regFile[{1'b0, a0[7:4], 1'b0}] == {8{$past(regFile[{2'b00, a0[3:0]}][7])}};
   endproperty
   a_sign: assert property (p_sign) else $error("sign extension wrong");

endmodule

// File: dv/data_move_instruction_decode_tb.sv
// Purpose: self-checking bench for the data move decoder
// Assumes: memory answers are played by hand in each scenario
// Notes: inputs move on the falling edge only
`timescale 1ns/1ns
module data_move_instruction_decode_tb
   import move_decode_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sourceMode = 1'b1;
   logic fetchValid = 1'b0;
   logic [7:0] fetchByte = 8'h00;
   logic [15:0] fetchPc = 16'h0000;
   logic memAck = 1'b0;
   logic [31:0] memRdata = 32'h0;
   logic fetchReady, carryBit, instrDone, instrIllegal;
   logic [7:0] acc;
   logic [15:0] dataPointer;
   memReq_t memReq;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   // request kinds: write flag, space, size
   localparam logic [4:0] WB = {1'b1, SPACE_DATA, SIZE_BYTE}, RB = {1'b0, SPACE_DATA, SIZE_BYTE};
   localparam logic [4:0] WW = {1'b1, SPACE_DATA, SIZE_WORD}, WD = {1'b1, SPACE_DATA, SIZE_DWORD};
   localparam logic [4:0] CR = {1'b0, SPACE_CODE, SIZE_BYTE}, BR = {1'b0, SPACE_BIT, SIZE_BYTE};
   localparam logic [4:0] BW = {1'b1, SPACE_BIT, SIZE_BYTE};

   data_move_instruction_decode u_dut (.clk(clk), .rst_b(rst_b), .sourceMode(sourceMode),
      .fetchValid(fetchValid), .fetchByte(fetchByte), .fetchPc(fetchPc), .fetchReady(fetchReady),
      .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .acc(acc), .dataPointer(dataPointer),
      .carryBit(carryBit), .instrDone(instrDone), .instrIllegal(instrIllegal));

   // ------------------------------------------------------------
   // clock, hang guard and helpers
   // ------------------------------------------------------------
   initial forever #5 clk = ~clk;

   // whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   task close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask

   // offer bytes in order; valid drops after the last so nothing is taken twice
   task op(input logic [7:0] b[$]);
      foreach (b[i])
      begin
         @(negedge clk);
         while (fetchReady !== 1'b1)
            @(negedge clk);
         fetchValid = 1'b1;
         fetchByte = b[i];
         fetchPc = fetchPc + 16'h0001;
         @(posedge clk);
      end
      @(negedge clk);
      fetchValid = 1'b0;
   endtask

   task fin(input string s, input logic ill);
      for (int k = 0; k < 8 && instrDone !== 1'b1 && instrIllegal !== 1'b1; k++)
         @(negedge clk);
      chk(s, {30'h0, !ill, ill}, {30'h0, instrDone, instrIllegal});
   endtask

   // bit requests: size is left open and only data bit 0 matters
   task xfer(input string s, input logic [7:0] b[$], input logic [4:0] k, input logic [23:0] a,
      input logic [31:0] wd, input logic [31:0] rd);
      op(b);
      for (int n = 0; n < 8 && memReq.valid !== 1'b1; n++)
         @(negedge clk);
      chk(s, {3'h1, k[4:2], (k[3:2] == SPACE_BIT) ? memReq.size : k[1:0], a},
         {2'h0, memReq[61:32]});
      // no byte may be taken while a request is outstanding
      chk(s, 32'h0, {31'h0, fetchReady});
      if (k[4])
         chk(s, wd, (k[3:2] == SPACE_BIT) ? {31'h0, memReq.wdata[0]} : memReq.wdata);
      memAck = 1'b1;
      memRdata = rd;
      @(negedge clk);
      memAck = 1'b0;
      fin(s, 1'b0);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_store();
      op('{8'h90, 8'h12, 8'h34});
      fin("ptr", 1'b0);
      chk("ptr", 32'h1234, {16'h0, dataPointer});
      op('{8'h7A, 8'h0C, 8'h11, 8'h22});
      fin("hi", 1'b0);
      xfer("dw", '{8'h7A, 8'h0F, 8'h00, 8'h40}, WD, 24'h40, 32'h11220000, 32'h0);
      xfer("b", '{8'h7A, 8'h13, 8'h12, 8'h34}, WB, 24'h1234, 32'h22, 32'h0);
   endtask

   task t_mode();
      sourceMode = 1'b0;
      op('{8'h7A});
      fin("bin", 1'b1);
      xfer("esc", '{8'hA5, 8'h7A, 8'h13, 8'h00, 8'h50}, WB, 24'h50, 32'h22, 32'h0);
      sourceMode = 1'b1;
      op('{8'hA5, 8'h7A});
      fin("src", 1'b1);
   endtask

   task t_disp();
      xfer("l09", '{8'h09, 8'h20, 8'hFF, 8'hFE}, RB, 24'h1120, 32'h0, 32'h77);
      xfer("l29", '{8'h29, 8'h30, 8'h80, 8'h00}, RB, 24'h21F700, 32'h0, 32'h9C);
      xfer("s19", '{8'h19, 8'h20, 8'h00, 8'h10}, WB, 24'h1132, 32'h77, 32'h0);
      xfer("s39", '{8'h39, 8'h30, 8'h00, 8'h01}, WB, 24'h22779D, 32'h9C, 32'h0);
      op('{8'h1A, 8'h23});
      fin("sx", 1'b0);
      xfer("s59", '{8'h59, 8'h20, 8'h00, 8'h00}, WW, 24'h1122, 32'hFF9C, 32'h0);
      xfer("1b", '{8'h1B, 8'h0A, 8'h20}, WW, 24'h22779C, 32'hFF9C, 32'h0);
      xfer("p9", '{8'h7A, 8'h09, 8'h20}, WB, 24'h1122, 32'h77, 32'h0);
      xfer("pb", '{8'h7A, 8'h0B, 8'h30}, WB, 24'h22779C, 32'h9C, 32'h0);
   endtask

   task t_code();
      fetchPc = 16'h1FFF;
      xfer("c83", '{8'h83}, CR, 24'h2001, 32'h0, 32'h5A);
      chk("acc", 32'h5A, {24'h0, acc});
      op('{8'h90, 8'hFF, 8'hF0});
      fin("ptr", 1'b0);
      xfer("c93", '{8'h93}, CR, 24'h004A, 32'h0, 32'hC3);
      chk("keep", 32'hC3FFF0, {8'h0, acc, dataPointer});
   endtask

   task t_bit();
      xfer("a2", '{8'hA2, 8'h40}, BR, 24'h40, 32'h0, 32'h1);
      chk("cy", 32'h1, {31'h0, carryBit});
      xfer("92", '{8'h92, 8'h41}, BW, 24'h41, 32'h1, 32'h0);
      xfer("a99", '{8'hA9, 8'h95, 8'h37}, BW, 24'h11BD, 32'h1, 32'h0);
      xfer("a9a", '{8'hA9, 8'hA2, 8'h38}, BR, 24'h11C2, 32'h0, 32'h0);
      chk("cy", 32'h0, {31'h0, carryBit});
      chk("keep", 32'hC3FFF0, {8'h0, acc, dataPointer});
   endtask

   initial
   begin
      repeat (10) @(negedge clk);
      chk("rst", 32'h0, {acc, dataPointer, 7'h0, carryBit});
      rst_b = 1'b1;
      t_store();
      t_mode();
      t_disp();
      t_code();
      t_bit();
      close_out();
   end
endmodule
